// ### verilog/sd_matrix_pkg.sv
package sd_matrix_pkg;

  // Number of host SD ports and card slots on each side of the crossbar.
  localparam int PORT_N = 2;
  localparam int SLOT_N = 2;

  // Host port and card slot indices.
  localparam int BOOT_PORT = 0;
  localparam int SEC_PORT = 1;
  localparam int LOWER_SLOT = 0;
  localparam int UPPER_SLOT = 1;

  // One SD bundle: clock, command and four data lines.
  localparam int LANE_W = 6;
  localparam int LANE_CLK = 0;
  localparam int LANE_CMD = 1;
  localparam int LANE_DAT_LSB = 2;
  localparam logic [5:0] LANE_IDLE = 6'h3F;
  localparam logic [5:0] LANE_ZERO = 6'h00;

  // Matrix control register: number and field positions.
  localparam logic [7:0] CTRL_REG_NUMBER = 8'h34;
  localparam int CTRL_W = 4;
  localparam int BIT_BOOT_EN = 0;
  localparam int BIT_SEC_EN = 1;
  localparam int BIT_BOOT_DEFAULT = 2;
  localparam int BIT_BOOT_UPPER = 3;

  // Power-up routing: boot port on the lower slot, secondary port open.
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // Rates: the routed paths are combinational up to the host limit.
  localparam int CLOCK_HZ = 25000000;
  localparam int SD_MAX_RATE_HZ = 50000000;

endpackage : sd_matrix_pkg

// ### verilog/sd_pin_sync.sv
`timescale 1ns/1ps
module sd_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic pin_in,
  output logic level_out
);

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic level_next;

  // The level follows only once the second and third stages agree.
  always_comb
  begin
    level_next = level_reg;
    if (ff2_reg == ff3_reg)
    begin
      level_next = ff3_reg;
    end
  end

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ff1_reg <= RESET_LEVEL;
      ff2_reg <= RESET_LEVEL;
      ff3_reg <= RESET_LEVEL;
      level_reg <= RESET_LEVEL;
    end
    else if (clk_en_in)
    begin
      ff1_reg <= pin_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule : sd_pin_sync

// ### verilog/sd_crossbar.sv
`timescale 1ns/1ps
module sd_crossbar (
  input wire logic [1:0][1:0] link_in,
  input wire logic [1:0][5:0] host_drv_in,
  input wire logic [1:0][5:0] host_oe_n_in,
  output logic [1:0][5:0] host_rx_out,
  input wire logic [1:0][5:0] card_rx_in,
  output logic [1:0][5:0] card_drv_out,
  output logic [1:0][5:0] card_oe_n_out
);

  // Each index is both one card slot and one host port; link_in is [port][slot].
  for (genvar i = 0; i < sd_matrix_pkg::SLOT_N; i++)
  begin : g_lane
    // Slot side: pass the driving port through, release the lines when open.
    always_comb
    begin
      card_drv_out[i] = sd_matrix_pkg::LANE_ZERO;
      card_oe_n_out[i] = sd_matrix_pkg::LANE_IDLE;
      if (link_in[sd_matrix_pkg::BOOT_PORT][i])
      begin
        card_drv_out[i] = host_drv_in[sd_matrix_pkg::BOOT_PORT];
        card_oe_n_out[i] = host_oe_n_in[sd_matrix_pkg::BOOT_PORT];
      end
      else if (link_in[sd_matrix_pkg::SEC_PORT][i])
      begin
        card_drv_out[i] = host_drv_in[sd_matrix_pkg::SEC_PORT];
        card_oe_n_out[i] = host_oe_n_in[sd_matrix_pkg::SEC_PORT];
      end
    end

    // Port side: return the joined slot, or an idle-high bundle when open.
    always_comb
    begin
      host_rx_out[i] = sd_matrix_pkg::LANE_IDLE;
      if (link_in[i][sd_matrix_pkg::LOWER_SLOT])
      begin
        host_rx_out[i] = card_rx_in[sd_matrix_pkg::LOWER_SLOT];
      end
      else if (link_in[i][sd_matrix_pkg::UPPER_SLOT])
      begin
        host_rx_out[i] = card_rx_in[sd_matrix_pkg::UPPER_SLOT];
      end
    end
  end

endmodule : sd_crossbar

// ### verilog/sd_matrix_switch.sv
// Function
// - Either slot may serve as boot card.
// - Two-by-two crossbar between host ports and slots.
// - Power-up: boot port on lower, secondary open.
// - Microcontroller reset keeps the present routing.
// - Boot port may be routed to upper slot.
// - Boot on lower: upper may join secondary.
// - Boot on upper: lower may join secondary.
// - Both host ports may be fully disconnected.
// - No card-usage check, no interlock.
// - Routed paths carry 50 MHz single-ended signalling.
// - Control lines set by control register writes.
// - One register holds four matrix settings.
`timescale 1ns/1ps
module sd_matrix_switch (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic mcu_run_n_in,
  input wire logic ctrl_wr_in,
  input wire logic [3:0] ctrl_data_in,
  output logic [3:0] settings_out,
  output logic boot_connect_out,
  output logic second_port_connect_flag_out,
  output logic boot_default_out,
  output logic boot_upper_out,
  output logic mcu_in_reset_out,
  output logic write_ignored_out,
  output logic route_changed_out,
  input wire logic [5:0] primary_host_sd_port_drv_in,
  input wire logic [5:0] primary_host_sd_port_oe_n_in,
  output logic [5:0] primary_host_sd_port_rx_out,
  input wire logic [5:0] secondary_sd_port_drv_in,
  input wire logic [5:0] secondary_sd_port_oe_n_in,
  output logic [5:0] secondary_sd_port_rx_out,
  input wire logic [5:0] lower_card_slot_rx_in,
  output logic [5:0] lower_card_slot_drv_out,
  output logic [5:0] lower_card_slot_oe_n_out,
  input wire logic [5:0] upper_card_slot_rx_in,
  output logic [5:0] upper_card_slot_drv_out,
  output logic [5:0] upper_card_slot_oe_n_out
);

  logic mcu_run_sync;
  logic mcu_in_reset;
  logic write_accepted;
  logic [3:0] settings_reg;
  logic [3:0] settings_next;
  logic ignored_reg;
  logic ignored_next;
  logic changed_reg;
  logic changed_next;
  logic boot_on;
  logic sec_on;
  logic boot_upper;
  logic [1:0][1:0] link;
  logic [1:0][5:0] host_drv;
  logic [1:0][5:0] host_oe_n;
  logic [1:0][5:0] host_rx;
  logic [1:0][5:0] card_rx;
  logic [1:0][5:0] card_drv;
  logic [1:0][5:0] card_oe_n;

  // The microcontroller run pin comes from another domain; high means running.
  sd_pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_run_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .pin_in(mcu_run_n_in),
    .level_out(mcu_run_sync)
  );

  // While the controller is in reset its lines may toggle, so writes are shut out.
  assign mcu_in_reset = ~mcu_run_sync;
  assign write_accepted = ctrl_wr_in & ~mcu_in_reset;

  // Next settings: a strobe marks a complete register write.
  // A write during a controller reset is dropped, so stray toggles cannot reroute the cards.
  always_comb
  begin
    settings_next = settings_reg;
    ignored_next = ignored_reg;
    changed_next = 1'b0;
    if (ctrl_wr_in)
    begin
      if (mcu_in_reset)
      begin
        ignored_next = 1'b1;
      end
      else
      begin
        settings_next = ctrl_data_in;
        ignored_next = 1'b0;
        changed_next = (ctrl_data_in != settings_reg);
      end
    end
  end

  // Settings register; reset stands for the power-up state, boot port on the lower slot.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      settings_reg <= sd_matrix_pkg::CTRL_RESET;
      ignored_reg <= 1'b0;
      changed_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      settings_reg <= settings_next;
      ignored_reg <= ignored_next;
      changed_reg <= changed_next;
    end
  end

  // Field decode of three of the four settings held in the control register.
  assign boot_on = settings_reg[sd_matrix_pkg::BIT_BOOT_EN];
  assign sec_on = settings_reg[sd_matrix_pkg::BIT_SEC_EN];
  assign boot_upper = settings_reg[sd_matrix_pkg::BIT_BOOT_UPPER];

  // Connection matrix; the secondary port always takes the other slot.
  always_comb
  begin
    link = '0;
    link[sd_matrix_pkg::BOOT_PORT][sd_matrix_pkg::LOWER_SLOT] = boot_on & ~boot_upper;
    link[sd_matrix_pkg::BOOT_PORT][sd_matrix_pkg::UPPER_SLOT] = boot_on & boot_upper;
    link[sd_matrix_pkg::SEC_PORT][sd_matrix_pkg::UPPER_SLOT] = sec_on & ~boot_upper;
    link[sd_matrix_pkg::SEC_PORT][sd_matrix_pkg::LOWER_SLOT] = sec_on & boot_upper;
  end

  // Gather the port bundles into the crossbar's indexed form.
  assign host_drv[sd_matrix_pkg::BOOT_PORT] = primary_host_sd_port_drv_in;
  assign host_drv[sd_matrix_pkg::SEC_PORT] = secondary_sd_port_drv_in;
  assign host_oe_n[sd_matrix_pkg::BOOT_PORT] = primary_host_sd_port_oe_n_in;
  assign host_oe_n[sd_matrix_pkg::SEC_PORT] = secondary_sd_port_oe_n_in;
  assign card_rx[sd_matrix_pkg::LOWER_SLOT] = lower_card_slot_rx_in;
  assign card_rx[sd_matrix_pkg::UPPER_SLOT] = upper_card_slot_rx_in;

  // Signal paths stay combinational so no clock edge limits the 50 MHz rate.
  sd_crossbar u_crossbar (
    .link_in(link),
    .host_drv_in(host_drv),
    .host_oe_n_in(host_oe_n),
    .host_rx_out(host_rx),
    .card_rx_in(card_rx),
    .card_drv_out(card_drv),
    .card_oe_n_out(card_oe_n)
  );

  // Spread the crossbar results back onto the named pins.
  assign primary_host_sd_port_rx_out = host_rx[sd_matrix_pkg::BOOT_PORT];
  assign secondary_sd_port_rx_out = host_rx[sd_matrix_pkg::SEC_PORT];
  assign lower_card_slot_drv_out = card_drv[sd_matrix_pkg::LOWER_SLOT];
  assign upper_card_slot_drv_out = card_drv[sd_matrix_pkg::UPPER_SLOT];
  assign lower_card_slot_oe_n_out = card_oe_n[sd_matrix_pkg::LOWER_SLOT];
  assign upper_card_slot_oe_n_out = card_oe_n[sd_matrix_pkg::UPPER_SLOT];

  // Status outputs, all taken from registers.
  assign settings_out = settings_reg;
  assign boot_connect_out = boot_on;
  assign second_port_connect_flag_out = sec_on;
  assign boot_default_out = settings_reg[sd_matrix_pkg::BIT_BOOT_DEFAULT];
  assign boot_upper_out = boot_upper;
  assign mcu_in_reset_out = mcu_in_reset;
  assign write_ignored_out = ignored_reg;
  assign route_changed_out = changed_reg;

  // Checks, all on the one clock and disabled while reset is held.
  default clocking cb_main @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // Power-up default is in place at the first cycle after release.
  property p_reset_default;
    $rose(rst_n_in) |-> (settings_reg == sd_matrix_pkg::CTRL_RESET) && boot_on && !sec_on
      && (lower_card_slot_drv_out == primary_host_sd_port_drv_in);
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("Routing after reset is not the power-up default.");

  // Writes during a controller reset leave the routing untouched.
  property p_hold_in_mcu_reset;
    (clk_en_in && mcu_in_reset && ctrl_wr_in) |=> $stable(settings_reg) && write_ignored_out;
  endproperty
  a_hold_in_mcu_reset: assert property (p_hold_in_mcu_reset)
    else $error("Routing changed while the controller was in reset.");

  // An accepted write is latched one cycle later and held after it.
  property p_apply_write;
    (clk_en_in && write_accepted) ##1 (!ctrl_wr_in)
      |-> (settings_reg == $past(ctrl_data_in)) ##1 $stable(settings_reg);
  endproperty
  a_apply_write: assert property (p_apply_write)
    else $error("Written routing was not applied or not held.");

  // No slot is ever joined to both host ports.
  property p_no_shared_slot;
    !(link[0][0] && link[1][0]) && !(link[0][1] && link[1][1]);
  endproperty
  a_no_shared_slot: assert property (p_no_shared_slot)
    else $error("Both host ports joined to one slot.");

  // Boot from the upper slot passes the primary port straight through.
  property p_boot_upper;
    (boot_on && boot_upper) |-> (upper_card_slot_drv_out == primary_host_sd_port_drv_in)
      && (primary_host_sd_port_rx_out == upper_card_slot_rx_in);
  endproperty
  a_boot_upper: assert property (p_boot_upper)
    else $error("Primary port not routed to the upper slot.");

  // Boot on lower with secondary enabled puts the upper slot on the secondary.
  property p_sec_upper;
    (!boot_upper && sec_on) |-> (upper_card_slot_oe_n_out == secondary_sd_port_oe_n_in)
      && (secondary_sd_port_rx_out == upper_card_slot_rx_in);
  endproperty
  a_sec_upper: assert property (p_sec_upper)
    else $error("Secondary port not routed to the upper slot.");

  // Boot on upper with secondary enabled puts the lower slot on the secondary.
  property p_sec_lower;
    (boot_upper && sec_on) |-> (lower_card_slot_drv_out == secondary_sd_port_drv_in)
      && (secondary_sd_port_rx_out == lower_card_slot_rx_in);
  endproperty
  a_sec_lower: assert property (p_sec_lower)
    else $error("Secondary port not routed to the lower slot.");

  // Both ports off leaves both slots released and both ports idle.
  property p_all_off;
    (!boot_on && !sec_on) |-> (lower_card_slot_oe_n_out == sd_matrix_pkg::LANE_IDLE)
      && (upper_card_slot_oe_n_out == sd_matrix_pkg::LANE_IDLE)
      && (primary_host_sd_port_rx_out == sd_matrix_pkg::LANE_IDLE)
      && (secondary_sd_port_rx_out == sd_matrix_pkg::LANE_IDLE);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("A slot stays connected with both ports disabled.");

  // A changed routing takes effect on the next cycle, with no interlock.
  property p_no_interlock;
    (clk_en_in && write_accepted && (ctrl_data_in != settings_reg))
      |=> route_changed_out && (boot_on == $past(ctrl_data_in[sd_matrix_pkg::BIT_BOOT_EN]))
      && (sec_on == $past(ctrl_data_in[sd_matrix_pkg::BIT_SEC_EN]));
  endproperty
  a_no_interlock: assert property (p_no_interlock)
    else $error("Routing change was delayed or blocked.");

  // Leaving reset clears both status flags.
  property p_reset_clean;
    $rose(rst_n_in) |-> !write_ignored_out && !route_changed_out;
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("Status flags not clear after reset.");

  // The change pulse only follows an accepted write.
  property p_changed_cause;
    (clk_en_in && !write_accepted) |=> !route_changed_out;
  endproperty
  a_changed_cause: assert property (p_changed_cause)
    else $error("Change pulse without an accepted write.");

  // An accepted write clears the ignored flag.
  property p_ignored_clear;
    (clk_en_in && write_accepted) |=> !write_ignored_out;
  endproperty
  a_ignored_clear: assert property (p_ignored_clear)
    else $error("Ignored flag stays set after an accepted write.");

  // A low clock enable freezes every piece of held state.
  property p_freeze;
    !clk_en_in |=> $stable(settings_reg) && $stable(write_ignored_out)
      && $stable(route_changed_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved while the clock enable was low.");

  // Boot from the lower slot joins the primary port to it in both directions.
  property p_boot_lower;
    (boot_on && !boot_upper) |-> (lower_card_slot_drv_out == primary_host_sd_port_drv_in)
      && (lower_card_slot_oe_n_out == primary_host_sd_port_oe_n_in)
      && (primary_host_sd_port_rx_out == lower_card_slot_rx_in);
  endproperty
  a_boot_lower: assert property (p_boot_lower)
    else $error("Primary port not routed to the lower slot.");

  // A disabled boot port sees an idle bundle.
  property p_boot_off;
    !boot_on |-> (primary_host_sd_port_rx_out == sd_matrix_pkg::LANE_IDLE);
  endproperty
  a_boot_off: assert property (p_boot_off)
    else $error("Disabled primary port still receives a slot.");

  // A disabled secondary port sees an idle bundle.
  property p_sec_off;
    !sec_on |-> (secondary_sd_port_rx_out == sd_matrix_pkg::LANE_IDLE);
  endproperty
  a_sec_off: assert property (p_sec_off)
    else $error("Disabled secondary port still receives a slot.");

  // The secondary port drives the upper slot when boot is on the lower one.
  property p_sec_upper_drv;
    (!boot_upper && sec_on) |-> (upper_card_slot_drv_out == secondary_sd_port_drv_in);
  endproperty
  a_sec_upper_drv: assert property (p_sec_upper_drv)
    else $error("Secondary port does not drive the upper slot.");

endmodule : sd_matrix_switch

// ### verification/sd_far_model.sv
`timescale 1ns/1ps
// Far side of the matrix: two host SD ports and two microSD cards.
module sd_far_model #(
  parameter logic [5:0] P_DRV = 6'h0C,
  parameter logic [5:0] P_OE = 6'h30,
  parameter logic [5:0] S_DRV = 6'h33,
  parameter logic [5:0] S_OE = 6'h0C,
  parameter logic [5:0] L_RX = 6'h15,
  parameter logic [5:0] U_RX = 6'h2A
) (
  output logic [5:0] p_drv_out,
  output logic [5:0] p_oe_n_out,
  output logic [5:0] s_drv_out,
  output logic [5:0] s_oe_n_out,
  output logic [5:0] l_rx_out,
  output logic [5:0] u_rx_out
);
  // The boot port drives a fixed pattern, so whatever slot it reaches shows it.
  assign p_drv_out = P_DRV;
  assign p_oe_n_out = P_OE;
  // The secondary port drives its own distinct pattern.
  assign s_drv_out = S_DRV;
  assign s_oe_n_out = S_OE;
  // Each card answers with a level pattern unique to its slot.
  assign l_rx_out = L_RX;
  assign u_rx_out = U_RX;
endmodule : sd_far_model

// ### verification/dual_card_slot_switch_matrix_test.sv
`timescale 1ns/1ps
module dual_card_slot_switch_matrix_test;
  localparam logic [5:0] P_DRV = 6'h0C;
  localparam logic [5:0] P_OE = 6'h30;
  localparam logic [5:0] S_DRV = 6'h33;
  localparam logic [5:0] S_OE = 6'h0C;
  localparam logic [5:0] L_RX = 6'h15;
  localparam logic [5:0] U_RX = 6'h2A;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic mcu_run_n_in = 1'b1;
  logic ctrl_wr_in = 1'b0;
  logic [3:0] ctrl_data_in = 4'h0;
  logic [3:0] settings_out;
  logic mcu_in_reset_out, write_ignored_out, route_changed_out;
  logic boot_connect_out, second_port_connect_flag_out, boot_default_out, boot_upper_out;
  logic [5:0] p_drv, p_oe_n, p_rx, s_drv, s_oe_n, s_rx;
  logic [5:0] l_rx, l_drv, l_oe_n, u_rx, u_drv, u_oe_n;
  logic [3:0] cur;
  int bad_count = 0;
  int samples_checked = 0;

  // Clock at 25 MHz.
  always #20 clock_in = ~clock_in;

  sd_far_model #(.P_DRV(P_DRV), .P_OE(P_OE), .S_DRV(S_DRV), .S_OE(S_OE), .L_RX(L_RX),
    .U_RX(U_RX)) far (.p_drv_out(p_drv), .p_oe_n_out(p_oe_n), .s_drv_out(s_drv),
    .s_oe_n_out(s_oe_n), .l_rx_out(l_rx), .u_rx_out(u_rx));

  sd_matrix_switch dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .mcu_run_n_in(mcu_run_n_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in),
    .settings_out(settings_out), .boot_connect_out(boot_connect_out),
    .second_port_connect_flag_out(second_port_connect_flag_out),
    .boot_default_out(boot_default_out), .boot_upper_out(boot_upper_out),
    .mcu_in_reset_out(mcu_in_reset_out),
    .write_ignored_out(write_ignored_out), .route_changed_out(route_changed_out),
    .primary_host_sd_port_drv_in(p_drv), .primary_host_sd_port_oe_n_in(p_oe_n),
    .primary_host_sd_port_rx_out(p_rx), .secondary_sd_port_drv_in(s_drv),
    .secondary_sd_port_oe_n_in(s_oe_n), .secondary_sd_port_rx_out(s_rx),
    .lower_card_slot_rx_in(l_rx), .lower_card_slot_drv_out(l_drv),
    .lower_card_slot_oe_n_out(l_oe_n), .upper_card_slot_rx_in(u_rx),
    .upper_card_slot_drv_out(u_drv), .upper_card_slot_oe_n_out(u_oe_n));

  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Issues one control write; entered and left just after a rising edge.
  task automatic put(input logic [3:0] d);
    ctrl_wr_in = 1'b1;
    ctrl_data_in = d;
    @(posedge clock_in);
    #1;
    ctrl_wr_in = 1'b0;
  endtask : put

  // Checks every routed path against the expected crossbar for settings s.
  task automatic routes(input logic [3:0] s);
    logic [5:0] e;
    e = !s[0] ? 6'h3F : (s[3] ? U_RX : L_RX);
    chk("primary rx", e, p_rx);
    e = !s[1] ? 6'h3F : (s[3] ? L_RX : U_RX);
    chk("secondary rx", e, s_rx);
    e = (s[0] && !s[3]) ? P_DRV : ((s[1] && s[3]) ? S_DRV : 6'h00);
    chk("lower drv", e, l_drv);
    e = (s[0] && !s[3]) ? P_OE : ((s[1] && s[3]) ? S_OE : 6'h3F);
    chk("lower oe_n", e, l_oe_n);
    e = (s[0] && s[3]) ? P_DRV : ((s[1] && !s[3]) ? S_DRV : 6'h00);
    chk("upper drv", e, u_drv);
    e = (s[0] && s[3]) ? P_OE : ((s[1] && !s[3]) ? S_OE : 6'h3F);
    chk("upper oe_n", e, u_oe_n);
  endtask : routes

  // Power-up routing: boot port on the lower slot, secondary port open.
  task automatic t_default;
    chk("settings", 6'h01, {2'b00, settings_out});
    routes(4'h1);
    cur = 4'h1;
  endtask : t_default

  // Walks all sixteen setting words, then rewrites the same word.
  task automatic t_table;
    logic [3:0] d;
    for (int i = 0; i < 17; i++)
    begin
      d = i[3:0] ^ {4{i == 16}};
      put(d);
      chk("settings", {2'b00, d}, {2'b00, settings_out});
      chk("boot connect", {5'h00, d[0]}, {5'h00, boot_connect_out});
      chk("second connect", {5'h00, d[1]}, {5'h00, second_port_connect_flag_out});
      chk("boot default", {5'h00, d[2]}, {5'h00, boot_default_out});
      chk("boot upper", {5'h00, d[3]}, {5'h00, boot_upper_out});
      chk("changed", {5'h00, d != cur}, {5'h00, route_changed_out});
      routes(d);
      cur = d;
      @(posedge clock_in);
      #1;
      chk("changed pulse", 6'h00, {5'h00, route_changed_out});
    end
  endtask : t_table

  // Controller reset freezes routing; clock enable low hides writes; reset restores default.
  task automatic t_mcu;
    put(4'h9);
    mcu_run_n_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    chk("mcu reset", 6'h01, {5'h00, mcu_in_reset_out});
    put(4'h6);
    @(posedge clock_in);
    #1;
    chk("settings", 6'h09, {2'b00, settings_out});
    chk("ignored", 6'h01, {5'h00, write_ignored_out});
    routes(4'h9);
    mcu_run_n_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    chk("mcu run", 6'h00, {5'h00, mcu_in_reset_out});
    put(4'h3);
    chk("settings", 6'h03, {2'b00, settings_out});
    chk("ignored", 6'h00, {5'h00, write_ignored_out});
    clk_en_in = 1'b0;
    put(4'hA);
    chk("settings", 6'h03, {2'b00, settings_out});
    chk("changed frozen", 6'h01, {5'h00, route_changed_out});
    clk_en_in = 1'b1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    chk("settings", 6'h01, {2'b00, settings_out});
    chk("ignored", 6'h00, {5'h00, write_ignored_out});
    chk("changed", 6'h00, {5'h00, route_changed_out});
    routes(4'h1);
  endtask : t_mcu

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    t_default();
    t_table();
    t_mcu();
    final_report();
  end
endmodule : dual_card_slot_switch_matrix_test
